// ===== verilog/rve_roof_voltage_enable.v
// roof voltage select and operation mode registers with converter enable gating
//
// Summary of operation
// R1: roof register holds gate, spare, six-bit code
// R2: reset gives gate one, spare zero, factory code
// R3: gate bit qualifies the external enable pin
// R4: gate bit shared by both voltage registers
// R5: gate zero forces shutdown regardless of pin
// R6: gate one follows the enable pin level
// R7: target equals minimum plus code times step; the 20-bit targetUv wraps instead for codes 24 and up
// R8: write takes effect at data LSB edge
// R9: no updates while pin holds hardware shutdown
// R10: minimum voltage is per-variant build constant
`timescale 1ns/1ps
`include "rve_regs.vh"
module rve_roof_voltage_enable #(
  parameter [5:0] ROOF_CODE_RESET = `RVE_CODE_RST,
  parameter [5:0] FLOOR_CODE_RESET = `RVE_CODE_RST,
  parameter [19:0] MIN_OUT_UV = `RVE_VMIN_UV
)
(
  input wire core_clk,
  input wire reset,
  input wire enablePin,
  input wire writeStrobe,
  input wire [7:0] writeAddr,
  input wire [7:0] writeData,
  input wire [7:0] readAddr,
  output reg [7:0] readData,
  output reg converterRun,
  output reg [5:0] activeCode,
  output reg [19:0] targetUv,
  output reg [1:0] modeCtrl,
  output reg modeHighSel,
  output reg modeLowSel
);
  // the block sits behind the serial front end, which hands over one
  // decoded byte write per strobe; reads are a plain registered mux

  // stored register fields; the gate is one flop behind two addresses,
  // so the floor and roof registers can never disagree about it
  reg converterOnGate;
  reg floorSpare;
  reg roofSpare;
  reg [5:0] floorCode;
  reg [5:0] roofCode;
  reg modeFree;
  reg [7:0] spareReg;

  // next values, worked out in one combinational process below
  reg next_converterOnGate;
  reg next_floorSpare;
  reg next_roofSpare;
  reg [5:0] next_floorCode;
  reg [5:0] next_roofCode;
  reg next_modeFree;
  reg [1:0] next_modeCtrl;
  reg next_modeHighSel;
  reg next_modeLowSel;
  reg [7:0] next_spareReg;

  // write qualification and per-register hits
  wire updateOk;
  wire floorHit;
  wire roofHit;
  wire modeHit;
  wire spareHit;

  // next values of the registered outputs
  wire [7:0] next_readData;
  wire next_converterRun;
  wire [19:0] next_targetUv;

  // one register image, used by the read mux for every address
  function [7:0] regImage;
    input [7:0] addr;
    begin
      case (addr)
        `RVE_OFS_FLOOR: regImage = {converterOnGate, floorSpare, floorCode};
        `RVE_OFS_ROOF: regImage = {converterOnGate, roofSpare, roofCode}; // R1 R4
        // reserved top bits and the unused bottom bit always read zero
        `RVE_OFS_MODE: regImage = {2'b00, modeFree, modeCtrl, modeHighSel, modeLowSel, 1'b0};
        `RVE_OFS_SPARE3: regImage = spareReg;
        default: regImage = 8'h00;
      endcase
    end
  endfunction

  // address compare, shared by all four write hits
  function addrHit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      addrHit = (addr == ofs);
    end
  endfunction

  // target voltage in microvolts; operands are widened on purpose so the
  // product cannot be cut short; 63 steps of 12500 fit well in 20 bits
  function [19:0] roofTarget;
    input [5:0] code;
    reg [19:0] stepProduct;
    begin
      stepProduct = {14'h0000, code} * {4'h0, `RVE_STEP_UV};
      roofTarget = MIN_OUT_UV + stepProduct;
    end
  endfunction

  // writes are dropped while the pin holds hardware shutdown; the gate bit
  // alone does not block the serial side, so software can wake the converter
  assign updateOk = writeStrobe & enablePin; // R9

  // one decoded hit per register; only one can be high for a given address
  assign floorHit = updateOk & addrHit(writeAddr, `RVE_OFS_FLOOR);
  assign roofHit = updateOk & addrHit(writeAddr, `RVE_OFS_ROOF); // R8
  assign modeHit = updateOk & addrHit(writeAddr, `RVE_OFS_MODE);
  assign spareHit = updateOk & addrHit(writeAddr, `RVE_OFS_SPARE3);

  // read image, run qualifier and target are formed here, registered below
  assign next_readData = regImage(readAddr);
  assign next_converterRun = converterOnGate & enablePin; // R3 R5 R6
  assign next_targetUv = roofTarget(roofCode); // R7 R10

  // next state of every stored field; hold is the default on every path
  always @*
  begin
    next_converterOnGate = converterOnGate;
    next_floorSpare = floorSpare;
    next_roofSpare = roofSpare;
    next_floorCode = floorCode;
    next_roofCode = roofCode;
    next_modeFree = modeFree;
    next_modeCtrl = modeCtrl;
    next_modeHighSel = modeHighSel;
    next_modeLowSel = modeLowSel;
    next_spareReg = spareReg;
    // floor register: same gate flop as the roof register
    if (floorHit)
    begin
      next_converterOnGate = writeData[`RVE_BIT_GATE]; // R4
      next_floorSpare = writeData[`RVE_BIT_SPARE];
      next_floorCode = writeData[`RVE_CODE_HI:`RVE_CODE_LO];
    end
    // roof register: gate, spare and six-bit code, all read/write
    if (roofHit)
    begin
      next_converterOnGate = writeData[`RVE_BIT_GATE]; // R1 R4
      next_roofSpare = writeData[`RVE_BIT_SPARE]; // R1
      next_roofCode = writeData[`RVE_CODE_HI:`RVE_CODE_LO]; // R1 R7
    end
    // mode register: the two top bits are reserved and never stored
    if (modeHit)
    begin
      next_modeFree = writeData[`RVE_BIT_MODE_FREE];
      next_modeCtrl = writeData[`RVE_MODE_CTRL_HI:`RVE_MODE_CTRL_LO];
      next_modeHighSel = writeData[`RVE_BIT_MODE_HIGH];
      next_modeLowSel = writeData[`RVE_BIT_MODE_LOW];
    end
    // fourth register: a plain byte with no side effects
    if (spareHit)
    begin
      next_spareReg = writeData;
    end
  end

  // stored fields; writeStrobe is the serial front end's pulse on the data
  // LSB edge, so a write lands on the clock edge that samples it
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      converterOnGate <= `RVE_GATE_RST; // R2
      roofSpare <= `RVE_SPARE_RST; // R2
      floorSpare <= `RVE_SPARE_RST;
      roofCode <= ROOF_CODE_RESET; // R2
      floorCode <= FLOOR_CODE_RESET;
      modeFree <= 1'b0;
      modeCtrl <= 2'b00;
      modeHighSel <= 1'b0;
      modeLowSel <= 1'b0;
      spareReg <= 8'h00;
    end
    else
    begin
      converterOnGate <= next_converterOnGate; // R4 R8
      roofSpare <= next_roofSpare;
      floorSpare <= next_floorSpare;
      roofCode <= next_roofCode; // R8
      floorCode <= next_floorCode;
      modeFree <= next_modeFree;
      modeCtrl <= next_modeCtrl;
      modeHighSel <= next_modeHighSel;
      modeLowSel <= next_modeLowSel;
      spareReg <= next_spareReg;
    end
  end

  // registered outputs: read image, run qualifier, code and target voltage;
  // they trail the stored fields by one edge, traded for clean flop outputs
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      readData <= 8'h00;
      converterRun <= 1'b0;
      activeCode <= 6'h00;
      targetUv <= 20'h0_0000;
    end
    else
    begin
      readData <= next_readData;
      converterRun <= next_converterRun; // R3 R5 R6
      activeCode <= roofCode;
      targetUv <= next_targetUv; // R7 R10
    end
  end
endmodule

// ===== verilog/rve_regs.vh
// register offsets, field positions, reset values and step figures for the roof voltage bank
`ifndef RVE_REGS_VH
`define RVE_REGS_VH
`define RVE_OFS_FLOOR 8'h00
`define RVE_OFS_ROOF 8'h01
`define RVE_OFS_MODE 8'h02
`define RVE_OFS_SPARE3 8'h03
`define RVE_BIT_GATE 7
`define RVE_BIT_SPARE 6
`define RVE_CODE_HI 5
`define RVE_CODE_LO 0
`define RVE_BIT_MODE_FREE 5
`define RVE_MODE_CTRL_HI 4
`define RVE_MODE_CTRL_LO 3
`define RVE_BIT_MODE_HIGH 2
`define RVE_BIT_MODE_LOW 1
`define RVE_GATE_RST 1'h1
`define RVE_SPARE_RST 1'h0
`define RVE_CODE_RST 6'h00
`define RVE_MODE_RST 6'h00
`define RVE_STEP_UV 16'h30D4
`define RVE_VMIN_UV 20'hB_71B0
`endif

// ===== verification/rve_host.sv
// host model
`timescale 1ns/1ps
module rve_host(input wire core_clk,output reg writeStrobe=0,
output reg [7:0] writeAddr=0,writeData=0,readAddr=8'h01);
task wr(input [7:0] a,d);
@(posedge core_clk) {writeStrobe,writeAddr,writeData,readAddr}<={1'h1,a,d,a};
@(posedge core_clk) writeStrobe<=0;
repeat (2) @(negedge core_clk);
endtask
task rd(input [7:0] a);
@(posedge core_clk) readAddr<=a;
repeat (2) @(negedge core_clk);
endtask
endmodule

// ===== verification/rve_monitor.sv
// bank checks
`timescale 1ns/1ps
module rve_monitor(input wire core_clk,reset,enablePin,writeStrobe,converterRun,
input wire [7:0] writeAddr,writeData,input wire [5:0] activeCode,input wire [19:0] targetUv);
default clocking @(posedge core_clk); endclocking
default disable iff (reset);
a_run_pin: assert property (converterRun|->$past(enablePin))
else $error("pin");
a_gate_off: assert property (writeStrobe&&enablePin&&writeAddr<8'h02&&!writeData[7]
|->##2 !converterRun) else $error("gate");
a_code_in: assert property (writeStrobe&&enablePin&&writeAddr==8'h01
|->##2 activeCode==$past(writeData[5:0],2)) else $error("code");
a_gate_on: assert property (writeStrobe&&enablePin&&writeAddr<8'h02&&writeData[7]
##1 enablePin |->##1 converterRun) else $error("gate on");
a_refused_hold: assert property (writeStrobe&&!enablePin|->##2 $stable(activeCode))
else $error("refused write landed");
a_target_step: assert property (!$past(reset)|->targetUv==20'hb_71b0+activeCode*20'h0_30d4)
else $error("target");
c_roof_write: cover property (writeStrobe&&enablePin&&writeAddr==8'h01);
c_refused: cover property (writeStrobe&&!enablePin);
c_run_on: cover property (converterRun);
endmodule
bind rve_roof_voltage_enable rve_monitor rve_monitor_inst(.*);

// ===== verification/tb.sv
// bank bench
`timescale 1ns/1ps
module tb;
reg core_clk=0,reset=1,enablePin=1;
wire writeStrobe,converterRun,modeHighSel,modeLowSel;
wire [7:0] writeAddr,writeData,readAddr,readData;
wire [1:0] modeCtrl;
wire [5:0] activeCode;
wire [19:0] targetUv;
integer errors=0,cmp_count=0,i,d,seed=32'hc3ae_5fbe;
always #10 core_clk=~core_clk;
rve_host rve_host_inst(.*);
rve_roof_voltage_enable rve_roof_voltage_enable_inst(.*);
task chk(input [19:0] s,e);
cmp_count=cmp_count+1;
errors=errors+(s!==e);
if (s!==e)
$display("mismatch %0t got %0h want %0h",$time,s,e);
endtask
task report_and_stop;
$display("n %0d e %0d",cmp_count,errors);
if (errors==0&&cmp_count>0)
$display("*** PASS ***");
else
$display("*** FAIL ***");
$finish;
endtask
initial
begin
repeat (5) @(posedge core_clk);
reset<=0;
repeat (3) @(negedge core_clk);
chk(readData,8'h80);
chk(targetUv,20'hb_71b0);
chk(converterRun,1'h1);
for (i=0;i<9;i=i+1)
begin
d=i?$random(seed)&8'hff:8'h3f;
rve_host_inst.wr(8'h01,d[7:0]);
chk(readData,d);
chk(activeCode,d[5:0]);
chk(converterRun,d[7]);
chk(targetUv,20'hb_71b0+d[5:0]*20'h0_30d4);
end
$display("roof sweep done");
rve_host_inst.wr(8'h00,8'h00);
chk(readData,8'h00);
rve_host_inst.rd(8'h01);
chk(readData,{1'h0,d[6:0]});
chk(converterRun,1'h0);
@(posedge core_clk) enablePin<=0;
rve_host_inst.wr(8'h01,8'h85);
chk(readData,{1'h0,d[6:0]});
chk(activeCode,d[5:0]);
@(posedge core_clk) enablePin<=1;
$display("refused write done");
for (i=0;i<4;i=i+1)
begin
d=$random(seed)&8'hff;
rve_host_inst.wr(8'h02,d[7:0]);
chk(readData,d&8'h3e);
chk(modeCtrl,d[4:3]);
chk(modeHighSel,d[2]);
chk(modeLowSel,d[1]);
rve_host_inst.wr(8'h03,d[7:0]);
chk(readData,d);
end
$display("mode and spare done");
@(posedge core_clk) reset<=1;
repeat (2) @(posedge core_clk);
reset<=0;
rve_host_inst.rd(8'h01);
chk(readData,8'h80);
chk(modeCtrl,2'h0);
chk(converterRun,1'h1);
$display("second reset done");
report_and_stop;
end
endmodule
